// file: rtl/flash_cmd_host.sv
/*
 * Host-side controller that runs write, erase and lock-bit command
 * sequences on a byte-wide flash, polls the status byte, performs the
 * full status check and returns the device to array read.
 * Assumes one synchronous clock; flash pins are timed by bus cycles.
 */
// Overview of operation
// - Byte write: setup 40H then data byte, same address.
// - After a command, poll status until ready bit reads one.
// - On any error, host clears status before retry; here a checked error sets need_clear_r and the user sends OP_CLEAR_STATUS.
// - Full status check per operation or after a series.
// - Writing FFH returns the device to array read.
// - Lock set: 60H then 01H block or F1H master.
// - Clear all block locks: 60H then D0H, any address.
// - Block erase: 20H then D0H within the block.
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_host #(
	parameter int ADDR_W = 21
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	// User command port
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire flash_seq_pkg::op_t cmd_op,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [7:0]        cmd_data,
	input  wire logic              cmd_check,
	output logic                   rsp_valid_r,
	output logic [7:0]             rsp_status_r,
	output logic [7:0]             rsp_rdata_r,
	output logic                   err_voltage_r,
	output logic                   err_protect_r,
	output logic                   err_sequence_r,
	output logic                   err_erase_r,
	output logic                   err_program_r,
	output logic                   need_clear_r,
	// Flash pins
	output logic [ADDR_W-1:0]      flash_addr_r,
	output logic [7:0]             flash_dq_out_r,
	output logic                   flash_dq_oe_r,
	input  wire logic [7:0]        flash_dq_in,
	output logic                   flash_ce_n_r,
	output logic                   flash_we_n_r,
	output logic                   flash_oe_n_r,
	input  wire logic              ready_busy_output
);
	// Address width the bus cycle and pins can carry
	if (ADDR_W < 1 || ADDR_W > 32) begin : bad_addr_w
		$error("flash_cmd_host: bad ADDR_W");
	end

	typedef enum logic [2:0] {
		S_IDLE    = 3'b000,
		S_SETUP   = 3'b001,
		S_CONFIRM = 3'b010,
		S_POLL    = 3'b011,
		S_SINGLE  = 3'b100,
		S_DONE    = 3'b101
	} state_t;

	state_t            state_r;
	flash_seq_pkg::op_t op_r;
	logic [ADDR_W-1:0] addr_r;
	logic [7:0]        data_r;
	logic              check_r;
	logic [7:0]        setup_code;
	logic [7:0]        confirm_code;
	logic [7:0]        single_code;
	logic              single_write;
	logic              bc_start;
	logic              bc_write;
	logic [7:0]        bc_wdata;
	logic              bc_busy;
	logic              bc_done;
	logic [7:0]        bc_rdata;
	logic              poll_ready;
	logic              bc_free;

	assign cmd_ready = (state_r == S_IDLE);

	// Codes for the latched operation
	always_comb begin
		setup_code   = flash_seq_pkg::CMD_LOCK_SETUP;
		confirm_code = flash_seq_pkg::CMD_CONFIRM;
		single_code  = flash_seq_pkg::CMD_READ_ARRAY;
		single_write = 1'b1;
		unique case (op_r)
			flash_seq_pkg::OP_BYTE_WRITE: begin
				setup_code   = flash_seq_pkg::CMD_WRITE_SETUP;
				confirm_code = data_r;
			end
			flash_seq_pkg::OP_BLOCK_ERASE: begin
				setup_code = flash_seq_pkg::CMD_ERASE_SETUP;
			end
			flash_seq_pkg::OP_BLOCK_LOCK: begin
				confirm_code = flash_seq_pkg::CMD_BLOCK_LOCK;
			end
			flash_seq_pkg::OP_MASTER_LOCK: begin
				confirm_code = flash_seq_pkg::CMD_MASTER_LOCK;
			end
			flash_seq_pkg::OP_CLEAR_LOCKS: begin
				confirm_code = flash_seq_pkg::CMD_CONFIRM;
			end
			flash_seq_pkg::OP_CLEAR_STATUS: begin
				single_code = flash_seq_pkg::CMD_CLEAR_STATUS;
			end
			flash_seq_pkg::OP_READ_ARRAY: begin
				single_code = flash_seq_pkg::CMD_READ_ARRAY;
			end
			flash_seq_pkg::OP_READ: begin
				single_write = 1'b0;
			end
		endcase
	end

	// Ready when both the pin and the status byte say so
	assign poll_ready = bc_rdata[flash_seq_pkg::BIT_READY]
		& ready_busy_output;

	// No start on the done edge: the state moves on there, so a start
	// would repeat the finished cycle
	assign bc_free = !bc_busy && !bc_done;

	// Bus cycle request for the current state
	always_comb begin
		bc_start = 1'b0;
		bc_write = 1'b1;
		bc_wdata = setup_code;
		unique case (state_r)
			S_SETUP: bc_start = bc_free;
			S_CONFIRM: begin
				bc_start = bc_free;
				bc_wdata = confirm_code;
			end
			S_POLL: begin
				bc_start = bc_free;
				bc_write = 1'b0;
			end
			S_SINGLE: begin
				bc_start = bc_free;
				bc_write = single_write;
				bc_wdata = single_code;
			end
			S_IDLE, S_DONE: bc_start = 1'b0;
			default: bc_start = 1'b0;
		endcase
	end

	// Sequence state machine
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_r <= S_IDLE;
			op_r    <= flash_seq_pkg::OP_READ;
			addr_r  <= '0;
			data_r  <= 8'h00;
			check_r <= 1'b0;
		end else begin
			unique case (state_r)
				S_IDLE: if (cmd_valid) begin
					op_r    <= cmd_op;
					addr_r  <= cmd_addr;
					data_r  <= cmd_data;
					check_r <= cmd_check;
					if (cmd_op == flash_seq_pkg::OP_CLEAR_STATUS ||
					    cmd_op == flash_seq_pkg::OP_READ_ARRAY ||
					    cmd_op == flash_seq_pkg::OP_READ)
						state_r <= S_SINGLE;
					else
						state_r <= S_SETUP;
				end
				S_SETUP:   if (bc_done) state_r <= S_CONFIRM;
				S_CONFIRM: if (bc_done) state_r <= S_POLL;
				S_POLL:    if (bc_done && poll_ready)
					state_r <= S_DONE;
				S_SINGLE:  if (bc_done) state_r <= S_DONE;
				S_DONE:    state_r <= S_IDLE;
				default:   state_r <= S_IDLE;
			endcase
		end
	end

	// Response and full status check
	always_ff @(posedge clk) begin
		rsp_valid_r <= 1'b0;
		if (!reset_n) begin
			rsp_status_r   <= 8'h00;
			rsp_rdata_r    <= 8'h00;
			err_voltage_r  <= 1'b0;
			err_protect_r  <= 1'b0;
			err_sequence_r <= 1'b0;
			err_erase_r    <= 1'b0;
			err_program_r  <= 1'b0;
			need_clear_r   <= 1'b0;
		end else if (state_r == S_DONE) begin
			rsp_valid_r <= 1'b1;
			if (op_r == flash_seq_pkg::OP_READ)
				rsp_rdata_r <= bc_rdata;
			else if (op_r == flash_seq_pkg::OP_CLEAR_STATUS)
				need_clear_r <= 1'b0;
		end else if (state_r == S_POLL && bc_done && poll_ready) begin
			rsp_status_r <= bc_rdata;
			if (check_r) begin
				err_voltage_r <= bc_rdata[flash_seq_pkg::BIT_VOLTAGE];
				err_protect_r <= bc_rdata[flash_seq_pkg::BIT_PROTECT];
				err_sequence_r <= bc_rdata[flash_seq_pkg::BIT_ERASE]
					& bc_rdata[flash_seq_pkg::BIT_PROGRAM];
				err_erase_r <= bc_rdata[flash_seq_pkg::BIT_ERASE]
					& !bc_rdata[flash_seq_pkg::BIT_PROGRAM];
				err_program_r <= bc_rdata[flash_seq_pkg::BIT_PROGRAM]
					& !bc_rdata[flash_seq_pkg::BIT_ERASE];
				if (bc_rdata[flash_seq_pkg::BIT_VOLTAGE] |
				    bc_rdata[flash_seq_pkg::BIT_PROTECT] |
				    bc_rdata[flash_seq_pkg::BIT_ERASE] |
				    bc_rdata[flash_seq_pkg::BIT_PROGRAM])
					need_clear_r <= 1'b1;
			end
		end
	end

	// Address: lock clear uses any address, zero here
	flash_bus_cycle #(
		.ADDR_W (ADDR_W)
	) u_cycle (
		.clk            (clk),
		.reset_n        (reset_n),
		.start          (bc_start),
		.is_write       (bc_write),
		.addr           ((op_r == flash_seq_pkg::OP_CLEAR_LOCKS) ?
			'0 : addr_r),
		.wdata          (bc_wdata),
		.busy           (bc_busy),
		.done           (bc_done),
		.rdata_r        (bc_rdata),
		.flash_addr_r   (flash_addr_r),
		.flash_dq_out_r (flash_dq_out_r),
		.flash_dq_oe_r  (flash_dq_oe_r),
		.flash_dq_in    (flash_dq_in),
		.flash_ce_n_r   (flash_ce_n_r),
		.flash_we_n_r   (flash_we_n_r),
		.flash_oe_n_r   (flash_oe_n_r)
	);
endmodule
`default_nettype wire

// file: rtl/flash_seq_pkg.sv
/*
 * Command codes, status bit positions and bus timing counts for the
 * flash command sequencer.
 * Assumes a byte-wide flash driven at 100 MHz by the host controller.
 */
package flash_seq_pkg;
	// Command codes written on the data bus
	localparam logic [7:0] CMD_WRITE_SETUP  = 8'h40;
	localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
	localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
	localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
	localparam logic [7:0] CMD_BLOCK_LOCK   = 8'h01;
	localparam logic [7:0] CMD_MASTER_LOCK  = 8'hF1;
	localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	// Status byte bit positions
	localparam int BIT_READY   = 7;
	localparam int BIT_ERASE   = 5;
	localparam int BIT_PROGRAM = 4;
	localparam int BIT_VOLTAGE = 3;
	localparam int BIT_PROTECT = 1;
	// Bus strobe timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int STROBE_NS     = 60;
	localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int GAP_NS        = 30;
	localparam int GAP_CYC       = (GAP_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// Operation codes on the user port
	typedef enum logic [2:0] {
		OP_BYTE_WRITE   = 3'b000,
		OP_BLOCK_ERASE  = 3'b001,
		OP_BLOCK_LOCK   = 3'b010,
		OP_MASTER_LOCK  = 3'b011,
		OP_CLEAR_LOCKS  = 3'b100,
		OP_CLEAR_STATUS = 3'b101,
		OP_READ_ARRAY   = 3'b110,
		OP_READ         = 3'b111
	} op_t;
endpackage

// file: rtl/flash_bus_cycle.sv
/*
 * One flash bus cycle: a write or a read strobe of fixed length,
 * followed by a recovery gap.
 * Assumes the flash data pins are joined outside from the enable.
 */
`timescale 1ns/1ns
`default_nettype none
module flash_bus_cycle #(
	parameter int ADDR_W = 21,
	parameter int STROBE = flash_seq_pkg::STROBE_CYC,
	parameter int GAP    = flash_seq_pkg::GAP_CYC
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              start,
	input  wire logic              is_write,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	output logic                   busy,
	output logic                   done,
	output logic [7:0]             rdata_r,
	output logic [ADDR_W-1:0]      flash_addr_r,
	output logic [7:0]             flash_dq_out_r,
	output logic                   flash_dq_oe_r,
	input  wire logic [7:0]        flash_dq_in,
	output logic                   flash_ce_n_r,
	output logic                   flash_we_n_r,
	output logic                   flash_oe_n_r
);
	// Counter is eight bits wide; both phases must fit in it
	if (STROBE < 1 || GAP < 1 || STROBE + GAP > 255) begin : bad_timing
		$error("flash_bus_cycle: bad timing");
	end

	logic [7:0] cnt_r;
	logic       strobe_r;
	logic       gap_r;

	assign busy = strobe_r | gap_r;

	// Strobe then gap sequencing
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (!reset_n) begin
			cnt_r    <= 8'h00;
			strobe_r <= 1'b0;
			gap_r    <= 1'b0;
		end else if (start && !busy) begin
			cnt_r    <= 8'(STROBE - 1);
			strobe_r <= 1'b1;
		end else if (cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end else if (strobe_r) begin
			strobe_r <= 1'b0;
			gap_r    <= 1'b1;
			cnt_r    <= 8'(GAP - 1);
		end else if (gap_r) begin
			gap_r <= 1'b0;
			done  <= 1'b1;
		end
	end

	// Pin drive
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			flash_addr_r   <= '0;
			flash_dq_out_r <= 8'h00;
			flash_dq_oe_r  <= 1'b0;
			flash_ce_n_r   <= 1'b1;
			flash_we_n_r   <= 1'b1;
			flash_oe_n_r   <= 1'b1;
		end else if (start && !busy) begin
			flash_addr_r   <= addr;
			flash_dq_out_r <= wdata;
			flash_dq_oe_r  <= is_write;
			flash_ce_n_r   <= 1'b0;
			flash_we_n_r   <= !is_write;
			flash_oe_n_r   <= is_write;
		end else if (strobe_r && cnt_r == 8'h00) begin
			flash_ce_n_r <= 1'b1;
			flash_we_n_r <= 1'b1;
			flash_oe_n_r <= 1'b1;
		end else if (!busy) begin
			flash_dq_oe_r <= 1'b0;
		end
	end

	// Read data captured at the end of the strobe
	always_ff @(posedge clk) begin
		if (!reset_n)
			rdata_r <= 8'h00;
		else if (strobe_r && cnt_r == 8'h00 && !flash_oe_n_r)
			rdata_r <= flash_dq_in;
	end
endmodule
`default_nettype wire

// file: sim/flash_cmd_host_props.sv
/* Checker for the flash command host: strobe shape, handshake and
 * error flag relations. Sees only the host ports; bound below. */
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_host_props (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic rsp_valid_r,
	input wire logic err_voltage_r,
	input wire logic err_protect_r,
	input wire logic err_sequence_r,
	input wire logic err_erase_r,
	input wire logic err_program_r,
	input wire logic need_clear_r,
	input wire logic flash_dq_oe_r,
	input wire logic flash_ce_n_r,
	input wire logic flash_we_n_r,
	input wire logic flash_oe_n_r,
	input wire logic ready_busy_output
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Any decoded error flag
	wire any_err = err_voltage_r | err_protect_r | err_sequence_r
		| err_erase_r | err_program_r;
	property p_strobe;
		$fell(flash_we_n_r) |-> !flash_we_n_r [*6] ##1 flash_we_n_r;
	endproperty
	property p_ce;
		!flash_we_n_r |-> !flash_ce_n_r && flash_dq_oe_r;
	endproperty
	property p_rd;
		!flash_oe_n_r |-> !flash_dq_oe_r && flash_we_n_r;
	endproperty
	property p_take;
		cmd_valid && cmd_ready |=> !cmd_ready;
	endproperty
	property p_pulse;
		rsp_valid_r |=> !rsp_valid_r;
	endproperty
	property p_seq;
		$rose(err_sequence_r) |-> need_clear_r;
	endproperty
	property p_flag;
		$changed(err_erase_r) || $changed(err_program_r) |-> !cmd_ready;
	endproperty
	property p_fail;
		err_erase_r |-> !err_program_r;
	endproperty
	property p_clear;
		$rose(need_clear_r) |-> ##[0:1] any_err;
	endproperty
	property p_busy;
		!ready_busy_output |-> !rsp_valid_r;
	endproperty
	a_strobe: assert property (p_strobe)
		else $error("write strobe length wrong");
	a_ce: assert property (p_ce)
		else $error("write without select or drive");
	a_rd: assert property (p_rd)
		else $error("read while driving bus");
	a_take: assert property (p_take)
		else $error("request taken twice");
	a_pulse: assert property (p_pulse)
		else $error("response longer than one cycle");
	a_seq: assert property (p_seq)
		else $error("sequence error without clear demand");
	a_flag: assert property (p_flag)
		else $error("fail flag moved outside an operation");
	a_fail: assert property (p_fail)
		else $error("erase and program flags together");
	a_clear: assert property (p_clear)
		else $error("clear demand without error");
	a_busy: assert property (p_busy)
		else $error("done while device busy");
	c_seq: cover property (rsp_valid_r && err_sequence_r);
	c_busy: cover property ($fell(ready_busy_output));
	c_clear: cover property ($rose(need_clear_r));
endmodule
bind flash_cmd_host flash_cmd_host_props u_flash_cmd_host_props (
	.clk               (clk),
	.reset_n           (reset_n),
	.cmd_valid         (cmd_valid),
	.cmd_ready         (cmd_ready),
	.rsp_valid_r       (rsp_valid_r),
	.err_voltage_r     (err_voltage_r),
	.err_protect_r     (err_protect_r),
	.err_sequence_r    (err_sequence_r),
	.err_erase_r       (err_erase_r),
	.err_program_r     (err_program_r),
	.need_clear_r      (need_clear_r),
	.flash_dq_oe_r     (flash_dq_oe_r),
	.flash_ce_n_r      (flash_ce_n_r),
	.flash_we_n_r      (flash_we_n_r),
	.flash_oe_n_r      (flash_oe_n_r),
	.ready_busy_output (ready_busy_output)
);
`default_nettype wire

// file: sim/flash_dev_model.sv
/* Behavioural byte-wide flash: command decode, status byte, busy time.
 * Assumes strobes from the host clock; tb injects error bits. */
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model (
	input  wire logic        clk,
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic [20:0] addr,
	input  wire logic [7:0]  dq_out,
	input  wire logic [7:0]  err_in,
	input  wire logic [7:0]  busy_len,
	output logic [7:0]       dq_in,
	output logic             ready_busy_output
);
	logic [7:0] mem [16];
	logic [7:0] sts_r = 8'h00, setup_r = 8'h00, dat_r = 8'h00;
	logic [7:0] last_r = 8'h00, cnt_r = 8'h00;
	logic [3:0] a_r = 4'h0;
	logic       we_p_r = 1'b1, stat_r = 1'b0;
	wire        rd = !ce_n && !oe_n;
	wire  [7:0] val = stat_r ? {cnt_r == 8'h00, sts_r[6:0]} : mem[addr[3:0]];
	// Released bus shows the inverse of the last value
	assign dq_in = rd ? val : ~last_r;
	assign ready_busy_output = (cnt_r == 8'h00);
	// Command decode on the end of each write strobe
	always @(posedge clk) begin
		we_p_r <= we_n;
		if (rd)
			last_r <= val;
		if (!we_n && !ce_n) begin
			dat_r <= dq_out;
			a_r <= addr[3:0];
		end
		if (cnt_r == 8'h01)
			sts_r <= sts_r | err_in;
		if (cnt_r != 8'h00)
			cnt_r <= cnt_r - 8'h01;
		if (!we_p_r && we_n) begin
			if (setup_r != 8'h00) begin
				setup_r <= 8'h00;
				stat_r <= 1'b1;
				cnt_r <= busy_len;
				if (setup_r == 8'h40)
					mem[a_r] <= dat_r;
				else if (setup_r == 8'h20 && dat_r == 8'hD0)
					mem[a_r] <= 8'hFF;
				else if (setup_r == 8'h20 || !(dat_r inside
					{8'h01, 8'hF1, 8'hD0}))
					sts_r[5:4] <= 2'b11;
			end else if (dat_r inside {8'h40, 8'h20, 8'h60})
				setup_r <= dat_r;
			else if (dat_r == 8'h50)
				sts_r <= 8'h00;
			else if (dat_r == 8'hFF)
				stat_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
/* Self-checking bench for the flash command host with a device model.
 * Assumes a 100 MHz clock and synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk, reset_n, cmd_valid, cmd_ready, cmd_check, rsp_valid_r;
	logic err_voltage_r, err_protect_r, err_sequence_r, err_erase_r;
	logic err_program_r, need_clear_r, flash_dq_oe_r, flash_ce_n_r;
	logic flash_we_n_r, flash_oe_n_r, ready_busy_output;
	flash_seq_pkg::op_t cmd_op;
	logic [20:0] cmd_addr, flash_addr_r;
	logic [7:0]  cmd_data, rsp_status_r, rsp_rdata_r, flash_dq_out_r;
	logic [7:0]  flash_dq_in, err_in, busy_len, dd [8];
	logic [7:0]  errs [5] = '{8'h10, 8'h20, 8'h02, 8'h08, 8'h30};
	logic [7:0]  flagv;
	int          bad_count = 0, checked = 0;
	// Decoded flags packed in the order of the flags function
	assign flagv = {3'b000, err_voltage_r, err_protect_r, err_sequence_r,
		err_erase_r, err_program_r};
	flash_cmd_host u_flash_cmd_host (
		.clk               (clk),
		.reset_n           (reset_n),
		.cmd_valid         (cmd_valid),
		.cmd_ready         (cmd_ready),
		.cmd_op            (cmd_op),
		.cmd_addr          (cmd_addr),
		.cmd_data          (cmd_data),
		.cmd_check         (cmd_check),
		.rsp_valid_r       (rsp_valid_r),
		.rsp_status_r      (rsp_status_r),
		.rsp_rdata_r       (rsp_rdata_r),
		.err_voltage_r     (err_voltage_r),
		.err_protect_r     (err_protect_r),
		.err_sequence_r    (err_sequence_r),
		.err_erase_r       (err_erase_r),
		.err_program_r     (err_program_r),
		.need_clear_r      (need_clear_r),
		.flash_addr_r      (flash_addr_r),
		.flash_dq_out_r    (flash_dq_out_r),
		.flash_dq_oe_r     (flash_dq_oe_r),
		.flash_dq_in       (flash_dq_in),
		.flash_ce_n_r      (flash_ce_n_r),
		.flash_we_n_r      (flash_we_n_r),
		.flash_oe_n_r      (flash_oe_n_r),
		.ready_busy_output (ready_busy_output)
	);
	flash_dev_model u_flash_dev_model (.clk(clk), .ce_n(flash_ce_n_r),
		.we_n(flash_we_n_r), .oe_n(flash_oe_n_r), .addr(flash_addr_r),
		.dq_out(flash_dq_out_r), .err_in(err_in), .busy_len(busy_len),
		.dq_in(flash_dq_in), .ready_busy_output(ready_busy_output));
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic results();
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Expected flags from a status byte
	function automatic logic [7:0] flags(input logic [7:0] s);
		return {3'b000, s[3], s[1], s[5] & s[4], s[5] & !s[4], s[4] & !s[5]};
	endfunction
	// One user request, waiting for its response
	task automatic run(input logic [2:0] op, input logic [20:0] a,
		input logic [7:0] d, input logic chk);
		int n;
		bit ok;
		busy_len <= 8'(1 + $urandom % 40);
		cmd_op <= flash_seq_pkg::op_t'(op);
		cmd_addr <= a;
		cmd_data <= d;
		cmd_check <= chk;
		cmd_valid <= 1'b1;
		n = 0;
		// Ready is looked at settled; the following edge takes the request
		#1;
		while (cmd_ready !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		cmd_valid <= 1'b0;
		ok = (n < 50);
		while (rsp_valid_r !== 1'b1 && n < 5000) begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		if (n >= 5000 || !ok) begin
			bad_count++;
			results();
		end
	endtask
	initial begin
		logic [20:0] a;
		reset_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = flash_seq_pkg::OP_READ;
		cmd_addr = 21'h00_0000;
		cmd_data = 8'h00;
		cmd_check = 1'b0;
		err_in = 8'h00;
		busy_len = 8'h01;
		void'($urandom(9));
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		// Each setup-and-confirm operation (ops 0 to 4) with one injected error, sticky, then cleared
		for (int i = 0; i < 5; i++) begin
			a = 21'($urandom % 16);
			err_in <= errs[i];
			run(3'(i), a, 8'($urandom), 1'b1);
			cmp8(rsp_status_r, 8'h80 | errs[i]);
			cmp8(flagv, flags(errs[i]));
			cmp8({7'h00, need_clear_r}, 8'h01);
			err_in <= 8'h00;
			run(3'd0, a, 8'($urandom), 1'b1);
			cmp8(rsp_status_r, 8'h80 | errs[i]);
			run(3'd5, a, 8'h00, 1'b0);
			cmp8({7'h00, need_clear_r}, 8'h00);
		end
		// Unchecked series of writes, then one check
		for (int i = 0; i < 8; i++) begin
			dd[i] = 8'($urandom);
			run(3'd0, 21'(i), dd[i], 1'b0);
		end
		cmp8(flagv, flags(errs[4]));
		run(3'd1, 21'h00_0003, 8'h00, 1'b1);
		cmp8(rsp_status_r, 8'h80);
		cmp8(flagv, flags(8'h80));
		dd[3] = 8'hFF;
		run(3'd7, 21'h00_0000, 8'h00, 1'b0);
		cmp8(rsp_rdata_r, 8'h80);
		run(3'd6, 21'h00_0000, 8'h00, 1'b0);
		for (int i = 0; i < 8; i++) begin
			run(3'd7, 21'(i), 8'h00, 1'b0);
			cmp8(rsp_rdata_r, dd[i]);
		end
		results();
	end
endmodule
`default_nettype wire
